/* File: sms_board_model.sv */
`timescale 1ns/1ns

module sms_board_model
  import sms_pkg::*;
(
  input wire logic mclk,
  input wire logic strap_gnd,
  input wire logic int_pull,
  input wire logic strap_oe,
  input wire logic int_oe,
  input wire sms_supply_t sup,
  output logic strap_level,
  output logic int_level,
  output logic main_reg_ok
);
  logic [2:0] ramp = 3'h0;

  // Strap pin has a pull-up; a grounded strap or the lamp driver pulls it low
  assign strap_level = !(strap_oe || strap_gnd);
  // Interrupt pin reads high only with the external pull-up fitted and no driver
  assign int_level = int_pull && !int_oe;

  // Main regulator output passes its reset threshold three cycles after enable
  always @(posedge mclk)
  begin
    ramp <= {ramp[1:0], sup.main_en};
  end
  assign main_reg_ok = ramp[2];
endmodule : sms_board_model

/* File: sms_defines.svh */
`ifndef SMS_DEFINES_SVH
`define SMS_DEFINES_SVH

// Time base
`define SMS_CLK_HZ 20000000
`define SMS_TMR_W 24

// Lamp waveforms: frequency in millihertz and duty in percent
`define SMS_SI_FREQ_MILLIHZ 1250
`define SMS_SI_DUTY_PCT 50
`define SMS_PL_FREQ_MILLIHZ 100000
`define SMS_PL_DUTY_PCT 20

// Mode timing in milliseconds
`define SMS_INIT_TMO_MS 256
`define SMS_POR_DELAY_MS 10
`define SMS_RESTART_DELAY_MS 10
`define SMS_FLASH_RST_MS 1

// Register indices
`define SMS_REG_CMD 4'h0
`define SMS_REG_STATUS 4'h1

// Command word fields
`define SMS_CMD_MS_LSB 0
`define SMS_CMD_WDSEL_BIT 3
`define SMS_CMD_AUX2_BIT 4
`define SMS_CMD_AUX3_BIT 5
`define SMS_CMD_LHEN_BIT 6
`define SMS_CMD_WKINH_LSB 7

// Mode select codes
`define SMS_MS_NORMAL 3'h0
`define SMS_MS_SLEEP 3'h1
`define SMS_MS_STOP 3'h2
`define SMS_MS_SWFLASH 3'h3
`define SMS_MS_RESTART 3'h4

`endif

/* File: sms_mode_ctrl.sv */
// Overview of operation
// - Side indicator: open-drain, 1.25 Hz, 50 percent
// - Pulsed light: open-drain, 100 Hz, 20 percent
// - Grounded strap pin selects development configuration
// - Ten modes chosen by strap and mode bits; SMS_FACTFLASH is never entered here
// - Five configurations from two pins, one bit
// - Config 1/3 miss: regulator kept, Restart
// - Config 2/4 miss: regulator off, Fail-Safe
// - Development mode still honours configurations 1-4
// - Power-up: strap, regulator, delay, then Init
// - Supply below off threshold disables everything
// - Strap sampled again on entering Init
// - Init: aux, CAN, limp-home off, watchdog idle
// - Init goes to commanded Normal or Flash
// - Init timeout or bad command: Restart, limp-home
// - Normal keeps main regulator on, watchdog running
// - Normal: commands switch auxiliary regulators
// - Normal: commands set limp-home, wake inhibits
// - Normal to Sleep/Stop/Flash; Flash pulses reset
// - Commands are 16-bit words
// - Interrupt pin strap picks 1/3 or 2/4
// - Restart exits to Normal, releasing reset
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "sms_defines.svh"

module sms_mode_ctrl
  import sms_pkg::*;
#(
  parameter int CLK_HZ = `SMS_CLK_HZ,
  parameter int SI_PERIOD = int'(64'(CLK_HZ) * 1000 / `SMS_SI_FREQ_MILLIHZ),
  parameter int SI_LOW = SI_PERIOD * `SMS_SI_DUTY_PCT / 100,
  parameter int PL_PERIOD = int'(64'(CLK_HZ) * 1000 / `SMS_PL_FREQ_MILLIHZ),
  parameter int PL_LOW = PL_PERIOD * `SMS_PL_DUTY_PCT / 100,
  parameter int INIT_TMO = int'(64'(CLK_HZ) * `SMS_INIT_TMO_MS / 1000),
  parameter int POR_DELAY = int'(64'(CLK_HZ) * `SMS_POR_DELAY_MS / 1000),
  parameter int RESTART_DELAY = int'(64'(CLK_HZ) * `SMS_RESTART_DELAY_MS / 1000),
  parameter int FLASH_RST = int'(64'(CLK_HZ) * `SMS_FLASH_RST_MS / 1000)
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic supply_ok,
  input wire logic main_reg_ok,
  input wire logic wd_miss,
  input wire logic wake_event,
  input wire logic devmode_strap_light_pin_in,
  output logic devmode_strap_light_pin_out,
  output logic devmode_strap_light_pin_oe,
  input wire logic int_pin_in,
  output logic int_pin_out,
  output logic int_pin_oe,
  output sms_od_t side_indicator_blink_out,
  output sms_od_t failsafe_output,
  output sms_supply_t supply_ctrl,
  output logic [2:0] wake_inhibit,
  output logic reset_output_n
);

  localparam int TMR_MAX = 2 ** `SMS_TMR_W;

  // Counters must fit the shared timer width
  initial
  begin
    if (SI_PERIOD < 2 || SI_LOW < 1 || SI_PERIOD > TMR_MAX || SI_LOW >= SI_PERIOD)
      $error("side indicator timing out of range");
    if (PL_PERIOD < 2 || PL_LOW < 1 || PL_PERIOD > TMR_MAX || PL_LOW >= PL_PERIOD)
      $error("pulsed light timing out of range");
    if (INIT_TMO < 1 || POR_DELAY < 1 || RESTART_DELAY < 1 || FLASH_RST < 1)
      $error("mode delays must be at least one cycle");
    if (INIT_TMO > TMR_MAX || POR_DELAY > TMR_MAX || RESTART_DELAY > TMR_MAX || FLASH_RST > TMR_MAX)
      $error("mode delays exceed timer width");
  end

  localparam logic [23:0] SI_END = 24'(SI_PERIOD - 1);
  localparam logic [23:0] SI_LOWC = 24'(SI_LOW);
  localparam logic [23:0] PL_END = 24'(PL_PERIOD - 1);
  localparam logic [23:0] PL_LOWC = 24'(PL_LOW);
  localparam logic [23:0] INIT_END = 24'(INIT_TMO - 1);
  localparam logic [23:0] POR_END = 24'(POR_DELAY - 1);
  localparam logic [23:0] RST_END = 24'(RESTART_DELAY - 1);
  localparam logic [23:0] FLR_END = 24'(FLASH_RST - 1);

  localparam sms_state_t RESET_STATE = '{
    mode: SMS_POR, sup: '0, strap_done: 1'b0, dev_mode: 1'b0, cfg_fs: 1'b0,
    wd_second: 1'b0, miss_seen: 1'b0, lh_active: 1'b0, wake_inh: 3'h0,
    reset_n: 1'b0, int_low: 1'b0, si_low: 1'b0, pl_low: 1'b0,
    rdata: 16'h0000, tmr: 24'h00_0000, si_cnt: 24'h00_0000, pl_cnt: 24'h00_0000
  };

  sms_state_t s;
  sms_state_t next_s;
  logic cmd_wr;
  logic [2:0] ms;
  logic [2:0] cfg_num;
  sms_mode_t run_mode;

  // Command decode
  assign cmd_wr = reg_wr && (reg_addr == `SMS_REG_CMD);
  assign ms = reg_wdata[`SMS_CMD_MS_LSB +: 3];
  assign run_mode = s.dev_mode ? SMS_SWDEV : SMS_NORMAL;
  assign cfg_num = s.dev_mode ? 3'h0 : 3'(3'h1 + {2'h0, s.cfg_fs} + {1'b0, s.wd_second, 1'b0});

  // Next-state logic for modes, timers, lamps and register reads
  always_comb
  begin
    next_s = s;
    next_s.rdata = 16'h0000;
    next_s.tmr = s.tmr + 24'h00_0001;
    if (!supply_ok)
    begin
      next_s = RESET_STATE;
    end
    else
    begin
      case (s.mode)
        SMS_POR:
        begin
          if (!s.strap_done)
          begin
            next_s.strap_done = 1'b1;
            next_s.dev_mode = !devmode_strap_light_pin_in;
            next_s.tmr = 24'h00_0000;
          end
          else
          begin
            next_s.sup.main_en = 1'b1;
            if (!main_reg_ok)
              next_s.tmr = 24'h00_0000;
            else if (s.tmr == POR_END)
            begin
              next_s.mode = SMS_INIT;
              next_s.reset_n = 1'b1;
              next_s.tmr = 24'h00_0000;
              next_s.dev_mode = !devmode_strap_light_pin_in;
              next_s.cfg_fs = !int_pin_in;
            end
          end
        end
        SMS_INIT:
        begin
          if (cmd_wr)
          begin
            next_s.wd_second = reg_wdata[`SMS_CMD_WDSEL_BIT];
            if (ms == `SMS_MS_NORMAL)
            begin
              next_s.mode = run_mode;
              next_s.sup.can_active = 1'b1;
              next_s.sup.wd_run = 1'b1;
            end
            else if (ms == `SMS_MS_SWFLASH)
            begin
              next_s.mode = SMS_SWFLASH;
              next_s.sup.can_active = 1'b1;
              next_s.tmr = FLR_END;
            end
            else
            begin
              next_s.mode = SMS_RESTART;
              next_s.lh_active = 1'b1;
              next_s.reset_n = 1'b0;
              next_s.tmr = 24'h00_0000;
            end
          end
          else if (s.tmr == INIT_END)
          begin
            next_s.mode = SMS_RESTART;
            next_s.lh_active = 1'b1;
            next_s.reset_n = 1'b0;
            next_s.tmr = 24'h00_0000;
          end
        end
        SMS_NORMAL, SMS_SWDEV:
        begin
          next_s.sup.main_en = 1'b1;
          if (wd_miss)
          begin
            next_s.sup.wd_run = 1'b0;
            next_s.reset_n = 1'b0;
            next_s.tmr = 24'h00_0000;
            if (s.wd_second && !s.miss_seen)
            begin
              next_s.miss_seen = 1'b1;
              next_s.mode = SMS_RESTART;
            end
            else
            begin
              next_s.miss_seen = 1'b0;
              next_s.lh_active = 1'b1;
              if (s.cfg_fs)
              begin
                next_s.mode = SMS_FAILSAFE;
                next_s.sup = '0;
              end
              else
                next_s.mode = SMS_RESTART;
            end
          end
          else if (cmd_wr)
          begin
            next_s.sup.aux2_en = reg_wdata[`SMS_CMD_AUX2_BIT];
            next_s.sup.aux3_en = reg_wdata[`SMS_CMD_AUX3_BIT];
            next_s.lh_active = reg_wdata[`SMS_CMD_LHEN_BIT];
            next_s.wake_inh = reg_wdata[`SMS_CMD_WKINH_LSB +: 3];
            next_s.wd_second = reg_wdata[`SMS_CMD_WDSEL_BIT];
            if (ms == `SMS_MS_SLEEP)
            begin
              next_s.mode = SMS_SLEEP;
              next_s.sup = '0;
            end
            else if (ms == `SMS_MS_STOP)
            begin
              next_s.mode = SMS_STOP;
              next_s.sup.can_active = 1'b0;
            end
            else if (ms == `SMS_MS_SWFLASH)
            begin
              next_s.mode = SMS_SWFLASH;
              next_s.reset_n = 1'b0;
              next_s.tmr = 24'h00_0000;
            end
          end
        end
        SMS_SWFLASH:
        begin
          if (s.tmr == FLR_END)
            next_s.reset_n = 1'b1;
          if (s.tmr >= FLR_END)
            next_s.tmr = s.tmr;
          if (wd_miss || (cmd_wr && ms == `SMS_MS_RESTART))
          begin
            next_s.mode = SMS_RESTART;
            next_s.reset_n = 1'b0;
            next_s.tmr = 24'h00_0000;
          end
          else if (cmd_wr)
            next_s.lh_active = reg_wdata[`SMS_CMD_LHEN_BIT];
        end
        SMS_RESTART:
        begin
          next_s.sup.main_en = 1'b1;
          if (s.tmr == RST_END)
          begin
            next_s.mode = run_mode;
            next_s.reset_n = 1'b1;
            next_s.sup.can_active = 1'b1;
            next_s.sup.wd_run = 1'b1;
          end
        end
        SMS_SLEEP, SMS_FAILSAFE:
        begin
          if (wake_event)
          begin
            next_s.mode = SMS_RESTART;
            next_s.reset_n = 1'b0;
            next_s.tmr = 24'h00_0000;
          end
        end
        SMS_STOP:
        begin
          if (wake_event)
            next_s.int_low = 1'b1;
          if (cmd_wr && ms == `SMS_MS_NORMAL)
          begin
            next_s.mode = run_mode;
            next_s.sup.can_active = 1'b1;
          end
        end
        default:
        begin
          next_s.mode = SMS_POR;
        end
      endcase
      if (s.mode != SMS_POR && s.mode != SMS_RESTART && s.mode != SMS_SWFLASH)
        next_s.tmr = (s.mode == SMS_INIT) ? next_s.tmr : 24'h00_0000;
      // Status read; a wake in the same cycle keeps the interrupt
      if (reg_rd && reg_addr == `SMS_REG_STATUS)
      begin
        next_s.rdata = {s.mode[9:0], cfg_num, s.lh_active, s.int_low, s.reset_n};
        if (!(s.mode == SMS_STOP && wake_event))
          next_s.int_low = 1'b0;
      end
      else if (reg_rd && reg_addr == `SMS_REG_CMD)
        next_s.rdata = {s.wake_inh, s.lh_active, s.sup.aux3_en, s.sup.aux2_en, s.wd_second, 9'h000};
      // Lamp waveforms run only while limp-home is active
      if (next_s.lh_active)
      begin
        next_s.si_cnt = (s.si_cnt == SI_END) ? 24'h00_0000 : s.si_cnt + 24'h00_0001;
        next_s.pl_cnt = (s.pl_cnt == PL_END) ? 24'h00_0000 : s.pl_cnt + 24'h00_0001;
      end
      else
      begin
        next_s.si_cnt = 24'h00_0000;
        next_s.pl_cnt = 24'h00_0000;
      end
      next_s.si_low = next_s.lh_active && (next_s.si_cnt < SI_LOWC);
      next_s.pl_low = next_s.lh_active && (next_s.pl_cnt < PL_LOWC);
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      s <= RESET_STATE;
    else if (clk_en)
      s <= next_s;
  end

  // Outputs straight from state; open-drain pins only pull low
  assign reg_rdata = s.rdata;
  assign supply_ctrl = s.sup;
  assign wake_inhibit = s.wake_inh;
  assign reset_output_n = s.reset_n;
  assign side_indicator_blink_out = '{out: 1'b0, oe: s.si_low};
  assign devmode_strap_light_pin_out = 1'b0;
  assign devmode_strap_light_pin_oe = s.pl_low;
  assign failsafe_output = '{out: 1'b0, oe: s.lh_active};
  assign int_pin_out = 1'b0;
  assign int_pin_oe = s.int_low;

  // Lamp enables never appear without limp-home
  property p_lamp_gate;
    @(posedge mclk) disable iff (!resetn)
    (s.si_low || s.pl_low) |-> s.lh_active;
  endproperty
  a_lamp_gate: assert property (p_lamp_gate) else $error("lamp driven without limp-home");

  // Side indicator low exactly in the first half of its period
  property p_si_duty;
    @(posedge mclk) disable iff (!resetn)
    s.lh_active |-> (s.si_low == (s.si_cnt < SI_LOWC));
  endproperty
  a_si_duty: assert property (p_si_duty) else $error("side indicator duty wrong");

  // Pulsed light low exactly in the first fifth of its period
  property p_pl_duty;
    @(posedge mclk) disable iff (!resetn)
    s.lh_active |-> (s.pl_low == (s.pl_cnt < PL_LOWC) && s.pl_cnt <= PL_END);
  endproperty
  a_pl_duty: assert property (p_pl_duty) else $error("pulsed light duty wrong");

  // Init is reached only after the full power-on delay
  property p_por_to_init;
    @(posedge mclk) disable iff (!resetn)
    (s.mode == SMS_POR) ##1 (s.mode == SMS_INIT) |-> $past(s.tmr) == POR_END && s.reset_n;
  endproperty
  a_por_to_init: assert property (p_por_to_init) else $error("Init entered early");

  // Supply loss drops everything back to power-on
  property p_supply_loss;
    @(posedge mclk) disable iff (!resetn)
    (!supply_ok && clk_en) |=> (s.mode == SMS_POR && !s.sup.main_en && !s.lh_active);
  endproperty
  a_supply_loss: assert property (p_supply_loss) else $error("supply loss not handled");

  // Init keeps outputs quiet
  property p_init_quiet;
    @(posedge mclk) disable iff (!resetn)
    (s.mode == SMS_INIT) |-> !s.sup.aux2_en && !s.sup.aux3_en && !s.sup.can_active && !s.lh_active && !s.sup.wd_run;
  endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("Init outputs active");

  // Init timeout goes to Restart with limp-home
  sequence s_init_expire;
    s.mode == SMS_INIT && s.tmr == INIT_END && clk_en && supply_ok && !cmd_wr;
  endsequence
  property p_init_tmo;
    @(posedge mclk) disable iff (!resetn)
    s_init_expire |=> (s.mode == SMS_RESTART && s.lh_active && !s.reset_n);
  endproperty
  a_init_tmo: assert property (p_init_tmo) else $error("Init timeout missed");

  // Miss in Fail-Safe configuration 2 (first-miss watchdog) cuts the regulator
  sequence s_miss_fs;
    s.mode == SMS_NORMAL && wd_miss && clk_en && supply_ok && s.cfg_fs && !s.wd_second;
  endsequence
  property p_miss_fs;
    @(posedge mclk) disable iff (!resetn)
    s_miss_fs |=> (s.mode == SMS_FAILSAFE && !s.sup.main_en && s.lh_active);
  endproperty
  a_miss_fs: assert property (p_miss_fs) else $error("Fail-Safe entry wrong");

  // Miss in a Restart configuration keeps the regulator on
  property p_miss_rs;
    @(posedge mclk) disable iff (!resetn)
    (s.mode == SMS_NORMAL && wd_miss && clk_en && supply_ok && !s.cfg_fs && !s.wd_second)
      |=> (s.mode == SMS_RESTART && s.sup.main_en && s.lh_active);
  endproperty
  a_miss_rs: assert property (p_miss_rs) else $error("Restart entry wrong");

  // Leaving Restart releases the reset output
  property p_restart_exit;
    @(posedge mclk) disable iff (!resetn)
    (s.mode == SMS_RESTART) ##1 (s.mode != SMS_RESTART && s.mode != SMS_POR) |-> $rose(s.reset_n);
  endproperty
  a_restart_exit: assert property (p_restart_exit) else $error("reset not released");

  // Unknown codes in Normal leave the mode alone
  property p_bad_code;
    @(posedge mclk) disable iff (!resetn)
    (s.mode == SMS_NORMAL && cmd_wr && clk_en && supply_ok && !wd_miss && ms > `SMS_MS_SWFLASH)
      |=> (s.mode == SMS_NORMAL);
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code changed mode");

endmodule : sms_mode_ctrl

/* File: sms_pkg.sv */
package sms_pkg;

  // Ten operating modes, one-hot
  typedef enum logic [9:0] {
    SMS_POR       = 10'b00_0000_0001,
    SMS_INIT      = 10'b00_0000_0010,
    SMS_NORMAL    = 10'b00_0000_0100,
    SMS_RESTART   = 10'b00_0000_1000,
    SMS_SWFLASH   = 10'b00_0001_0000,
    SMS_SLEEP     = 10'b00_0010_0000,
    SMS_STOP      = 10'b00_0100_0000,
    SMS_FAILSAFE  = 10'b00_1000_0000,
    SMS_SWDEV     = 10'b01_0000_0000,
    SMS_FACTFLASH = 10'b10_0000_0000
  } sms_mode_t;

  // Regulator and transceiver enables
  typedef struct packed {
    logic main_en;
    logic aux2_en;
    logic aux3_en;
    logic can_active;
    logic wd_run;
  } sms_supply_t;

  // Open-drain pin as output level plus enable
  typedef struct packed {
    logic out;
    logic oe;
  } sms_od_t;

  // Whole block state
  typedef struct packed {
    sms_mode_t mode;
    sms_supply_t sup;
    logic strap_done;
    logic dev_mode;
    logic cfg_fs;
    logic wd_second;
    logic miss_seen;
    logic lh_active;
    logic [2:0] wake_inh;
    logic reset_n;
    logic int_low;
    logic si_low;
    logic pl_low;
    logic [15:0] rdata;
    logic [23:0] tmr;
    logic [23:0] si_cnt;
    logic [23:0] pl_cnt;
  } sms_state_t;

endpackage : sms_pkg

/* File: test_sms_mode_ctrl.sv */
`timescale 1ns/1ns

module test_sms_mode_ctrl
  import sms_pkg::*;
;
  localparam int SIP = 20, SIL = 10, PLP = 10, PLL = 2, TMO = 50, PORD = 8, RSTD = 6, FLR = 4;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic clk_en = 1'h1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic supply_ok = 1'h1;
  logic wd_miss = 1'h0;
  logic wake_event = 1'h0;
  logic strap_gnd = 1'h0;
  logic int_pull = 1'h1;
  logic [15:0] reg_rdata;
  logic main_reg_ok, strap_in, strap_out, strap_oe, int_in, int_oe;
  sms_od_t side_ind, failsafe;
  sms_supply_t sup;
  logic [2:0] wake_inh;
  logic rst_n_out;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  logic [15:0] d, cw;
  logic [31:0] r;
  sms_mode_t tgt [3] = '{SMS_SLEEP, SMS_STOP, SMS_SWFLASH};

  // Free-running 20 MHz clock
  always #25 mclk = ~mclk;

  sms_mode_ctrl #(.SI_PERIOD(SIP), .SI_LOW(SIL), .PL_PERIOD(PLP), .PL_LOW(PLL), .INIT_TMO(TMO),
    .POR_DELAY(PORD), .RESTART_DELAY(RSTD), .FLASH_RST(FLR)) i_sms_mode_ctrl (
    .mclk(mclk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .supply_ok(supply_ok),
    .main_reg_ok(main_reg_ok), .wd_miss(wd_miss), .wake_event(wake_event),
    .devmode_strap_light_pin_in(strap_in), .devmode_strap_light_pin_out(strap_out),
    .devmode_strap_light_pin_oe(strap_oe), .int_pin_in(int_in), .int_pin_out(),
    .int_pin_oe(int_oe), .side_indicator_blink_out(side_ind), .failsafe_output(failsafe),
    .supply_ctrl(sup), .wake_inhibit(wake_inh), .reset_output_n(rst_n_out));

  sms_board_model i_sms_board_model (.mclk(mclk), .strap_gnd(strap_gnd), .int_pull(int_pull),
    .strap_oe(strap_oe), .int_oe(int_oe), .sup(sup), .strap_level(strap_in), .int_level(int_in),
    .main_reg_ok(main_reg_ok));

  // Expected status word and configuration number
  function automatic logic [15:0] st(input sms_mode_t m, input logic [2:0] c, input logic lh, input logic rs);
    return {m, c, lh, 1'h0, rs};
  endfunction : st

  function automatic logic [2:0] cfg(input logic g, input logic p, input logic w);
    return g ? 3'h0 : (p ? (w ? 3'h3 : 3'h1) : (w ? 3'h4 : 3'h2));
  endfunction : cfg

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'h0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
    @(posedge mclk);
    #1 chk("rdata_idle", 16'h0000, reg_rdata);
  endtask : rd

  task automatic miss();
    @(posedge mclk);
    wd_miss <= 1'h1;
    @(posedge mclk);
    wd_miss <= 1'h0;
    #1;
  endtask : miss

  task automatic wait_rel(output int c);
    c = 0;
    while (rst_n_out !== 1'h1 && c < 200)
    begin
      @(posedge mclk);
      #1 c++;
    end
  endtask : wait_rel

  // Power up with the given straps and check the Init state
  task automatic pwr(input logic g, input logic p);
    @(posedge mclk);
    resetn <= 1'h0;
    strap_gnd <= g;
    int_pull <= p;
    supply_ok <= 1'h1;
    repeat (4) @(posedge mclk);
    resetn <= 1'h1;
    wait_rel(n);
    chk("por_len", 16'h0001, 16'(n >= PORD && n < 200));
    rd(4'h1, d);
    chk("init_stat", st(SMS_INIT, cfg(g, p, 1'h0), 1'h0, 1'h1), d);
    chk("init_sup", 16'h0010, 16'(sup));
    chk("init_lamps", 16'h0000, {13'h0000, failsafe.oe, side_ind.oe, strap_oe});
  endtask : pwr

  // Count driven-low cycles of both lamp pins over two blink periods
  task automatic lamps(input logic on);
    int s, q;
    s = 0;
    q = 0;
    repeat (2 * SIP)
    begin
      @(posedge mclk);
      #1;
      if (side_ind.oe === 1'h1)
        s++;
      if (strap_oe === 1'h1)
        q++;
    end
    chk("side_low", 16'(on ? 2 * SIL : 0), 16'(s));
    chk("pulse_low", 16'(on ? 2 * SIP / PLP * PLL : 0), 16'(q));
    chk("lh_pin", 16'(on), 16'(failsafe.oe));
    chk("od_out", 16'h0000, {13'h0000, side_ind.out, failsafe.out, strap_out});
  endtask : lamps

  // Cycle ceiling against a hung design
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      bad_count++;
      stop_test();
    end
  end

  initial
  begin
    n = $urandom(46);
    // Configurations 1 to 4: first or second watchdog miss
    for (int p = 1; p >= 0; p--)
      for (int w = 0; w < 2; w++)
      begin
        pwr(1'h0, p[0]);
        r = $urandom;
        cw = {6'h00, r[2:0], 1'h0, r[4:3], w[0], 3'h0};
        wr(4'h0, cw);
        wr(4'h0, cw);
        chk("nrm_sup", {11'h000, 1'h1, r[3], r[4], 2'h3}, 16'(sup));
        chk("nrm_wake", {13'h0000, r[2:0]}, {13'h0000, wake_inh});
        for (int c = 5; c < 8; c++)
          wr(4'h0, cw | 16'(c));
        wr({1'h1, r[10:8]}, r[31:16]);
        rd({1'h1, r[7:5]}, d);
        chk("unmapped", 16'h0000, d);
        rd(4'h1, d);
        chk("nrm_stat", st(SMS_NORMAL, cfg(1'h0, p[0], w[0]), 1'h0, 1'h1), d);
        if (w)
        begin
          miss();
          chk("miss1", 16'h0002, {13'h0000, rst_n_out, sup.main_en, failsafe.oe});
          wait_rel(n);
        end
        miss();
        chk("miss_act", {14'h0000, p[0], 1'h1}, {13'h0000, rst_n_out, sup.main_en, failsafe.oe});
        rd(4'h1, d);
        chk("miss_mode", 16'(p ? SMS_RESTART : SMS_FAILSAFE), 16'(d[15:6]));
        lamps(1'h1);
        if (p)
        begin
          wait_rel(n);
          rd(4'h1, d);
          chk("back_nrm", st(SMS_NORMAL, cfg(1'h0, 1'h1, w[0]), 1'h1, 1'h1), d);
          wr(4'h0, cw);
          lamps(1'h0);
        end
        $display("config test p=%0d w=%0d done", p, w);
      end
    // Mode commands from Normal
    for (int i = 0; i < 3; i++)
    begin
      pwr(1'h0, 1'h1);
      wr(4'h0, 16'h0000);
      wr(4'h0, 16'(i + 1));
      if (i == 2)
        chk("flash_rst", 16'h0000, 16'(rst_n_out));
      rd(4'h1, d);
      chk("cmd_mode", 16'(tgt[i]), 16'(d[15:6]));
      // Wake in Stop raises the interrupt; a status read clears it
      if (i == 1)
      begin
        @(posedge mclk);
        wake_event <= 1'h1;
        @(posedge mclk);
        wake_event <= 1'h0;
        #1 chk("stop_wake", 16'h0001, 16'(int_oe));
        rd(4'h1, d);
        chk("int_clr", 16'h0002, {14'h0000, d[1], int_oe});
      end
    end
    // Supply drop disables everything
    @(posedge mclk);
    supply_ok <= 1'h0;
    @(posedge mclk);
    #1 chk("uv_off", 16'h0000, {7'h00, rst_n_out, sup, failsafe.oe, side_ind.oe, strap_oe});
    $display("mode command test done");
    // Init: flash command, wrong command, time-out
    pwr(1'h0, 1'h1);
    wr(4'h0, 16'h0003);
    rd(4'h1, d);
    chk("init_flash", 16'(SMS_SWFLASH), 16'(d[15:6]));
    pwr(1'h0, 1'h0);
    wr(4'h0, 16'h0001);
    chk("init_wrong", 16'h0001, {14'h0000, rst_n_out, failsafe.oe});
    pwr(1'h0, 1'h1);
    repeat (TMO - 8) @(posedge mclk);
    #1 chk("tmo_early", 16'h0000, 16'(failsafe.oe));
    repeat (12) @(posedge mclk);
    #1 chk("tmo_late", 16'h0001, 16'(failsafe.oe));
    $display("init test done");
    // Development strap
    pwr(1'h1, 1'h1);
    wr(4'h0, 16'h0000);
    rd(4'h1, d);
    chk("dev_mode", 16'(SMS_SWDEV), 16'(d[15:6]));
    $display("development test done");
    stop_test();
  end
endmodule : test_sms_mode_ctrl
